// ==== analyzer_pkg.sv ====
// constants and carrier types shared by the analyzer interface block
package analyzer_pkg;
   // ========================================
   // timing
   localparam int unsigned CLK_HZ     = 25_000_000;
   localparam int unsigned BAUD       = 9600;
   localparam int unsigned BAUD_CYC   = CLK_HZ / BAUD;
   localparam int unsigned REPORT_MS  = 2000;
   localparam int unsigned REPORT_CYC = (CLK_HZ / 1000) * REPORT_MS;
   localparam int unsigned CAL_MS     = 1000;
   localparam int unsigned CAL_CYC    = (CLK_HZ / 1000) * CAL_MS;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned RPT_LEN    = 23;
   // ========================================
   // characters
   localparam logic [7:0] CH_CR   = 8'h0d;
   localparam logic [7:0] CH_LF   = 8'h0a;
   localparam logic [7:0] CH_A    = 8'h61;
   localparam logic [7:0] CH_S    = 8'h73;
   localparam logic [7:0] CH_Z    = 8'h7a;
   localparam logic [7:0] CH_T    = 8'h74;
   localparam logic [7:0] CH_LO   = 8'h4c;
   localparam logic [7:0] CH_MED  = 8'h4d;
   localparam logic [7:0] CH_HI   = 8'h48;
   localparam logic [7:0] CH_AIR  = 8'h41;
   localparam logic [7:0] CH_DASH = 8'h2d;
   localparam logic [7:0] CH_DEF  = 8'h44;
   localparam logic [7:0] CH_TRIP = 8'h54;
   // ========================================
   // types and reset values
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_ZERO = 2'b01,
      CAL_SPAN = 2'b10,
      CAL_DONE = 2'b11
   } cal_e;
   typedef struct packed {
      logic        defeated;
      logic        high;
      logic        failsafe;
      logic        latching;
      logic [15:0] setpoint;
   } alarm_cfg_s;
   localparam alarm_cfg_s CFG_DEF = '{defeated: 1'b1, high: 1'b1,
      failsafe: 1'b0, latching: 1'b0, setpoint: 16'h03e8};
endpackage

// ==== analyzer_io.sv ====
// alarm relays, remote calibration, valves, range relays and serial port
//
// Contract
// - each threshold alarm trips above (high) or below (low) its setpoint
// - each alarm independently failsafe, latching, or defeated (never acts)
// - system alarm trips on any supply fault or failed self-test
// - system alarm is always failsafe and latching, never disabled
// - remote zero input high means on; on enters zero calibration
// - remote span input on enters span calibration, same levels
// - calibration returns to analysis only after its request goes off
// - cal busy contact closed during zero or span calibration only
// - with busy open the device analyzes and polls both request inputs, only the finished kind's in the done cycle
// - requests during a running calibration are dropped, not queued
// - request still on at completion restarts that calibration, busy again
// - exactly one of four range relays closed: low, medium, high, air
// - sample, zero, span, exhaust valve lines follow calibration state
// - status report every two seconds, five items in fixed order
// - every report item ends with carriage return then line feed
// - autospan or autozero command plus enter starts that calibration
// - report toggle command plus enter stops or resumes reports
// - serial link is 9600 baud, 8 data bits, no parity, 1 stop
// - factory reset sets alarms defeated, 1000 ppm, high, plain
`timescale 1ns/1ps
`default_nettype none

// ========================================
// byte fifo
module byte_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_r, rp_r, wp_nxt, rp_nxt;
   logic         push, pop;

   always_comb begin
      in_ready  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
      out_valid = wp_r != rp_r;
      out_data  = mem[rp_r[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_nxt    = wp_r + (AW+1)'(push);
      rp_nxt    = rp_r + (AW+1)'(pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (ce) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // storage has no reset, only pointers matter
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

// ========================================
// top
module analyzer_io #(
   parameter int unsigned REPORT_CYCLES = analyzer_pkg::REPORT_CYC,
   parameter int unsigned CAL_CYCLES    = analyzer_pkg::CAL_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic [15:0]              conc,
   input  wire logic [15:0]              span_ppm,
   input  wire logic [1:0]               range_sel,
   input  wire analyzer_pkg::alarm_cfg_s cfg_in,
   input  wire logic [1:0]               cfg_wr,
   input  wire logic                     factory_reset,
   input  wire logic                     alarm_ack,
   input  wire logic [3:0]               supply_fault,
   input  wire logic                     selftest_fail,
   input  wire logic                     zero_req_pin,
   input  wire logic                     span_req_pin,
   input  wire logic                     rxd_pin,
   output logic [1:0]                    alarm_relay,
   output logic                          sys_relay,
   output logic                          cal_busy,
   output logic                          low_range_indicator,
   output logic                          medium_range_indicator,
   output logic                          high_range_indicator,
   output logic                          air_cal_range_indicator,
   output logic                          valve_sample,
   output logic                          valve_zero,
   output logic                          valve_span,
   output logic                          valve_exhaust,
   output logic [1:0]                    alarm_defeated_report,
   output logic [1:0]                    alarm_tripped_report,
   output logic                          report_on,
   output logic                          txd
);
   // ========================================
   // threshold and system alarms
   analyzer_pkg::alarm_cfg_s cfg_r [2];
   analyzer_pkg::alarm_cfg_s cfg_nxt [2];
   logic [1:0] act_r, act_nxt, relay_r, relay_nxt;
   logic       sys_act_r, sys_act_nxt, sys_cond;

   for (genvar i = 0; i < 2; i++) begin : g_alarm
      logic cond;
      always_comb begin
         cfg_nxt[i] = factory_reset ? analyzer_pkg::CFG_DEF :
                      cfg_wr[i] ? cfg_in : cfg_r[i];
         cond = cfg_r[i].high ? (conc > cfg_r[i].setpoint)
                              : (conc < cfg_r[i].setpoint);
         // set wins over acknowledge
         act_nxt[i] = !cfg_r[i].defeated && (cond ||
                      (cfg_r[i].latching && act_r[i] && !alarm_ack));
         relay_nxt[i] = cfg_r[i].failsafe ? !act_nxt[i] : act_nxt[i];
      end
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            cfg_r[i] <= analyzer_pkg::CFG_DEF;
         end else if (ce) begin
            cfg_r[i] <= cfg_nxt[i];
         end
      end
   end

   always_comb begin
      sys_cond    = (|supply_fault) || selftest_fail;
      sys_act_nxt = sys_cond || (sys_act_r && !alarm_ack);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_r     <= 2'h0;
         relay_r   <= 2'h0;
         sys_act_r <= 1'b0;
         sys_relay <= 1'b1;
      end else if (ce) begin
         act_r     <= act_nxt;
         relay_r   <= relay_nxt;
         sys_act_r <= sys_act_nxt;
         sys_relay <= !sys_act_nxt;
      end
   end
   assign alarm_relay = relay_r;

   // ========================================
   // pin synchronisers, three flops, agree on last two
   logic [2:0] zs_r, ss_r, rs_r;
   logic       zreq_r, sreq_r, rx_lvl_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zs_r     <= 3'h0;
         ss_r     <= 3'h0;
         rs_r     <= 3'h7;
         zreq_r   <= 1'b0;
         sreq_r   <= 1'b0;
         rx_lvl_r <= 1'b1;
      end else if (ce) begin
         zs_r <= {zs_r[1:0], zero_req_pin};
         ss_r <= {ss_r[1:0], span_req_pin};
         rs_r <= {rs_r[1:0], rxd_pin};
         if (zs_r[1] == zs_r[2]) zreq_r <= zs_r[2];
         if (ss_r[1] == ss_r[2]) sreq_r <= ss_r[2];
         if (rs_r[1] == rs_r[2]) rx_lvl_r <= rs_r[2];
      end
   end

   // ========================================
   // serial receiver and command parser
   localparam logic [11:0] BAUD_M1 = 12'(analyzer_pkg::BAUD_CYC - 1);
   localparam logic [11:0] BAUD_H  = 12'(analyzer_pkg::BAUD_CYC / 2);
   logic       rx_busy_r, rx_busy_nxt, rx_vld_r, rx_vld_nxt;
   logic [11:0] rx_cnt_r, rx_cnt_nxt;
   logic [3:0] rx_bit_r, rx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt, c0_r, c0_nxt, c1_r, c1_nxt;
   logic       cmd_zero, cmd_span, rpt_en_r, rpt_en_nxt;

   always_comb begin
      rx_busy_nxt = rx_busy_r;
      rx_cnt_nxt  = rx_cnt_r;
      rx_bit_nxt  = rx_bit_r;
      rx_sh_nxt   = rx_sh_r;
      rx_vld_nxt  = 1'b0;
      if (!rx_busy_r) begin
         if (!rx_lvl_r) begin
            rx_busy_nxt = 1'b1;
            rx_cnt_nxt  = BAUD_H;
            rx_bit_nxt  = 4'h0;
         end
      end else if (rx_cnt_r != 12'h000) begin
         rx_cnt_nxt = rx_cnt_r - 12'h001;
      end else begin
         rx_cnt_nxt = BAUD_M1;
         rx_bit_nxt = rx_bit_r + 4'h1;
         if (rx_bit_r == 4'h0 && rx_lvl_r) begin
            rx_busy_nxt = 1'b0;
         end else if (rx_bit_r == 4'h9) begin
            rx_busy_nxt = 1'b0;
            rx_vld_nxt  = rx_lvl_r;
         end else if (rx_bit_r != 4'h0) begin
            rx_sh_nxt = {rx_lvl_r, rx_sh_r[7:1]};
         end
      end
      // commands are two letters then enter
      c0_nxt     = rx_vld_r ? rx_sh_r : c0_r;
      c1_nxt     = rx_vld_r ? c0_r : c1_r;
      cmd_zero   = rx_vld_r && rx_sh_r == analyzer_pkg::CH_CR &&
                   {c1_r, c0_r} == {analyzer_pkg::CH_A, analyzer_pkg::CH_Z};
      cmd_span   = rx_vld_r && rx_sh_r == analyzer_pkg::CH_CR &&
                   {c1_r, c0_r} == {analyzer_pkg::CH_A, analyzer_pkg::CH_S};
      rpt_en_nxt = rpt_en_r ^ (rx_vld_r &&
                   rx_sh_r == analyzer_pkg::CH_CR &&
                   {c1_r, c0_r} == {analyzer_pkg::CH_S, analyzer_pkg::CH_T});
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r  <= 12'h000;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 8'h00;
         rx_vld_r  <= 1'b0;
         c0_r      <= 8'h00;
         c1_r      <= 8'h00;
         rpt_en_r  <= 1'b1;
      end else if (ce) begin
         rx_busy_r <= rx_busy_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         rx_bit_r  <= rx_bit_nxt;
         rx_sh_r   <= rx_sh_nxt;
         rx_vld_r  <= rx_vld_nxt;
         c0_r      <= c0_nxt;
         c1_r      <= c1_nxt;
         rpt_en_r  <= rpt_en_nxt;
      end
   end
   assign report_on = rpt_en_r;

   // ========================================
   // calibration sequencer
   analyzer_pkg::cal_e st_r, st_nxt;
   logic        kind_span_r, kind_span_nxt;
   logic [25:0] cal_cnt_r, cal_cnt_nxt;
   logic [3:0]  range_r;
   logic [3:0]  valve_r, valve_nxt;
   logic        busy_nxt;

   always_comb begin
      st_nxt        = st_r;
      kind_span_nxt = kind_span_r;
      cal_cnt_nxt   = cal_cnt_r + 26'h1;
      unique case (st_r)
         analyzer_pkg::CAL_IDLE: begin
            // both requests polled only here, so busy-time requests are simply lost
            cal_cnt_nxt = 26'h0;
            if (zreq_r || cmd_zero) begin
               st_nxt        = analyzer_pkg::CAL_ZERO;
               kind_span_nxt = 1'b0;
            end else if (sreq_r || cmd_span) begin
               st_nxt        = analyzer_pkg::CAL_SPAN;
               kind_span_nxt = 1'b1;
            end
         end
         analyzer_pkg::CAL_ZERO, analyzer_pkg::CAL_SPAN: begin
            if (cal_cnt_r == 26'(CAL_CYCLES - 1)) begin
               st_nxt = analyzer_pkg::CAL_DONE;
            end
         end
         analyzer_pkg::CAL_DONE: begin
            cal_cnt_nxt = 26'h0;
            if (kind_span_r ? sreq_r : zreq_r) begin
               st_nxt = kind_span_r ? analyzer_pkg::CAL_SPAN
                                    : analyzer_pkg::CAL_ZERO;
            end else begin
               st_nxt = analyzer_pkg::CAL_IDLE;
            end
         end
      endcase
      busy_nxt  = st_nxt == analyzer_pkg::CAL_ZERO ||
                  st_nxt == analyzer_pkg::CAL_SPAN;
      valve_nxt = {busy_nxt, st_nxt == analyzer_pkg::CAL_SPAN,
                   st_nxt == analyzer_pkg::CAL_ZERO, !busy_nxt};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r        <= analyzer_pkg::CAL_IDLE;
         kind_span_r <= 1'b0;
         cal_cnt_r   <= 26'h0;
         cal_busy    <= 1'b0;
         valve_r     <= 4'h1;
         range_r     <= 4'h1;
      end else if (ce) begin
         st_r        <= st_nxt;
         kind_span_r <= kind_span_nxt;
         cal_cnt_r   <= cal_cnt_nxt;
         cal_busy    <= busy_nxt;
         valve_r     <= valve_nxt;
         range_r     <= 4'h1 << range_sel;
      end
   end
   assign {valve_exhaust, valve_span, valve_zero, valve_sample} = valve_r;
   assign {air_cal_range_indicator, high_range_indicator,
           medium_range_indicator, low_range_indicator} = range_r;
   assign alarm_tripped_report  = act_r;
   assign alarm_defeated_report = {cfg_r[1].defeated, cfg_r[0].defeated};

   // ========================================
   // status report, fifo and transmitter
   logic [25:0] tick_r, tick_nxt;
   logic        seq_r, seq_nxt, f_ready, f_valid;
   logic [4:0]  idx_r, idx_nxt;
   logic [15:0] conc_s_r, span_s_r;
   logic [1:0]  rng_s_r;
   logic        snap;
   logic [7:0]  rpt_byte, f_data;
   logic        tx_busy_r, tx_busy_nxt, txd_nxt;
   logic [11:0] tx_cnt_r, tx_cnt_nxt;
   logic [3:0]  tx_bit_r, tx_bit_nxt;
   logic [8:0]  tx_sh_r, tx_sh_nxt;

   function automatic logic [7:0] hex(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   always_comb begin
      tick_nxt = (tick_r == 26'(REPORT_CYCLES - 1)) ? 26'h0
                                                     : tick_r + 26'h1;
      snap     = tick_r == 26'h0 && rpt_en_r && !seq_r;
      seq_nxt  = seq_r;
      idx_nxt  = idx_r;
      if (snap) begin
         seq_nxt = 1'b1;
         idx_nxt = 5'h0;
      end else if (seq_r && f_ready) begin
         idx_nxt = idx_r + 5'h1;
         seq_nxt = idx_r != 5'(analyzer_pkg::RPT_LEN - 1);
      end
      unique case (idx_r)
         5'h00: rpt_byte = hex(conc_s_r[15:12]);
         5'h01: rpt_byte = hex(conc_s_r[11:8]);
         5'h02: rpt_byte = hex(conc_s_r[7:4]);
         5'h03: rpt_byte = hex(conc_s_r[3:0]);
         5'h06: rpt_byte = rng_s_r == 2'h0 ? analyzer_pkg::CH_LO :
                           rng_s_r == 2'h1 ? analyzer_pkg::CH_MED :
                           rng_s_r == 2'h2 ? analyzer_pkg::CH_HI :
                                             analyzer_pkg::CH_AIR;
         5'h09: rpt_byte = hex(span_s_r[15:12]);
         5'h0a: rpt_byte = hex(span_s_r[11:8]);
         5'h0b: rpt_byte = hex(span_s_r[7:4]);
         5'h0c: rpt_byte = hex(span_s_r[3:0]);
         5'h0f, 5'h10: rpt_byte = cfg_r[idx_r[0] ? 0 : 1].defeated ?
                           analyzer_pkg::CH_DEF : analyzer_pkg::CH_DASH;
         5'h13, 5'h14: rpt_byte = act_r[idx_r[0] ? 0 : 1] ?
                           analyzer_pkg::CH_TRIP : analyzer_pkg::CH_DASH;
         5'h04, 5'h07, 5'h0d, 5'h11, 5'h15:
            rpt_byte = analyzer_pkg::CH_CR;
         default: rpt_byte = analyzer_pkg::CH_LF;
      endcase
      // transmitter, stop bit rides in the shifter
      tx_busy_nxt = tx_busy_r;
      tx_cnt_nxt  = tx_cnt_r;
      tx_bit_nxt  = tx_bit_r;
      tx_sh_nxt   = tx_sh_r;
      txd_nxt     = txd;
      if (!tx_busy_r) begin
         if (f_valid) begin
            tx_busy_nxt = 1'b1;
            tx_sh_nxt   = {1'b1, f_data};
            txd_nxt     = 1'b0;
            tx_cnt_nxt  = BAUD_M1;
            tx_bit_nxt  = 4'h0;
         end
      end else if (tx_cnt_r != 12'h000) begin
         tx_cnt_nxt = tx_cnt_r - 12'h001;
      end else if (tx_bit_r == 4'h9) begin
         tx_busy_nxt = 1'b0;
      end else begin
         txd_nxt    = tx_sh_r[0];
         tx_sh_nxt  = {1'b1, tx_sh_r[8:1]};
         tx_bit_nxt = tx_bit_r + 4'h1;
         tx_cnt_nxt = BAUD_M1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_r    <= 26'h0;
         seq_r     <= 1'b0;
         idx_r     <= 5'h0;
         conc_s_r  <= 16'h0000;
         span_s_r  <= 16'h0000;
         rng_s_r   <= 2'h0;
         tx_busy_r <= 1'b0;
         tx_cnt_r  <= 12'h000;
         tx_bit_r  <= 4'h0;
         tx_sh_r   <= 9'h1ff;
         txd       <= 1'b1;
      end else if (ce) begin
         tick_r    <= tick_nxt;
         seq_r     <= seq_nxt;
         idx_r     <= idx_nxt;
         if (snap) begin
            conc_s_r <= conc;
            span_s_r <= span_ppm;
            rng_s_r  <= range_sel;
         end
         tx_busy_r <= tx_busy_nxt;
         tx_cnt_r  <= tx_cnt_nxt;
         tx_bit_r  <= tx_bit_nxt;
         tx_sh_r   <= tx_sh_nxt;
         txd       <= txd_nxt;
      end
   end

   byte_fifo #(.W(8), .D(analyzer_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_data   (rpt_byte),
      .in_valid  (seq_r),
      .in_ready  (f_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (!tx_busy_r)
   );

   // ========================================
   // checks
   property p_busy;
      @(posedge clk) disable iff (rst)
      cal_busy == (st_r == analyzer_pkg::CAL_ZERO ||
                   st_r == analyzer_pkg::CAL_SPAN);
   endproperty
   a_busy: assert property (p_busy) else $error("busy mismatch");
   property p_drop;
      @(posedge clk) disable iff (rst)
      (st_r == analyzer_pkg::CAL_ZERO && ce && (sreq_r || cmd_span))
      |=> st_r != analyzer_pkg::CAL_SPAN;
   endproperty
   a_drop: assert property (p_drop) else $error("request queued");
   property p_again;
      @(posedge clk) disable iff (rst)
      (st_r == analyzer_pkg::CAL_DONE && ce && !kind_span_r && zreq_r)
      |=> st_r == analyzer_pkg::CAL_ZERO ##1 cal_busy;
   endproperty
   a_again: assert property (p_again) else $error("no restart");
   property p_range;
      @(posedge clk) disable iff (rst) $onehot(range_r);
   endproperty
   a_range: assert property (p_range) else $error("range relays");
   property p_syslatch;
      @(posedge clk) disable iff (rst)
      (sys_act_r && !alarm_ack && ce) |=> sys_act_r && !sys_relay;
   endproperty
   a_syslatch: assert property (p_syslatch) else $error("sys drop");
   property p_defeat;
      @(posedge clk) disable iff (rst)
      (cfg_r[0].defeated && ce) |=> !act_r[0];
   endproperty
   a_defeat: assert property (p_defeat) else $error("defeated act");
   property p_valve;
      @(posedge clk) disable iff (rst)
      cal_busy |-> !valve_sample && valve_exhaust &&
                   (valve_zero != valve_span);
   endproperty
   a_valve: assert property (p_valve) else $error("valve lines");
   property p_txidle;
      @(posedge clk) disable iff (rst)
      (!tx_busy_r && !f_valid && ce) |=> txd;
   endproperty
   a_txidle: assert property (p_txidle) else $error("line not idle");
   property p_crlf;
      @(posedge clk) disable iff (rst)
      (seq_r && idx_r == 5'h05) |-> rpt_byte == analyzer_pkg::CH_LF;
   endproperty
   a_crlf: assert property (p_crlf) else $error("no line feed");
endmodule
`default_nettype wire

// ==== plc_model.sv ====
// remote calibration controller model: zero, span, then a zero held past completion
`timescale 1ns/1ps
`default_nettype none
module plc_model (
   input  wire logic clk,
   input  wire logic start,
   input  wire logic cal_busy,
   output logic      zero_req_pin,
   output logic      span_req_pin,
   output logic      done
);
   // ========================================
   // one request, held until busy closes
   task automatic req(input bit z, input bit hold);
      while (cal_busy) @(negedge clk);
      @(posedge clk);
      #1 {zero_req_pin, span_req_pin} = {z, !z};
      while (!cal_busy) @(negedge clk);
      // held past completion on purpose, device must run it again
      if (hold) while (cal_busy) @(negedge clk);
      @(posedge clk);
      // dropped at once, else the device repeats
      #1 {zero_req_pin, span_req_pin} = 2'b00;
   endtask
   initial begin
      {zero_req_pin, span_req_pin, done} = 3'b000;
      @(posedge start);
      req(1'b1, 1'b0);
      req(1'b0, 1'b0);
      req(1'b1, 1'b1);
      while (cal_busy) @(negedge clk);
      done = 1'b1;
   end
endmodule
`default_nettype wire

// ==== analyzer_io_tb_top.sv ====
// self-checking bench for the analyzer interface block
`timescale 1ns/1ps
`default_nettype none
module analyzer_io_tb_top;
   localparam int B = analyzer_pkg::BAUD_CYC;
   logic        clk, rst, ce, factory_reset, alarm_ack, selftest_fail;
   logic        rxd_pin, zero_req_pin, span_req_pin, go, pdone, lb;
   logic        sys_relay, cal_busy, report_on, txd;
   logic        low_range_indicator, medium_range_indicator;
   logic        high_range_indicator, air_cal_range_indicator;
   logic        valve_sample, valve_zero, valve_span, valve_exhaust;
   logic [15:0] conc, span_ppm;
   logic [1:0]  range_sel, cfg_wr, alarm_relay;
   logic [1:0]  alarm_defeated_report, alarm_tripped_report;
   logic [3:0]  supply_fault;
   logic [7:0]  b;
   int          mismatches, cmp_count, i, j, n, ph;
   analyzer_pkg::alarm_cfg_s cfg_in;

   // shortened counts keep the run short
   analyzer_io #(.REPORT_CYCLES(700000), .CAL_CYCLES(50)) dut_u (.*);
   plc_model plc_u (.clk(clk), .start(go), .cal_busy(cal_busy),
      .zero_req_pin(zero_req_pin), .span_req_pin(span_req_pin),
      .done(pdone));

   // ========================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int k = 0; k < 10; k++) begin
         rxd_pin = f[k];
         #(40 * B);
      end
   endtask
   task automatic ack;
      alarm_ack = 1'b1;
      tick(1);
      alarm_ack = 1'b0;
      tick(3);
   endtask
   function automatic logic relay_exp(analyzer_pkg::alarm_cfg_s c,
                                      logic [15:0] v);
      logic t;
      t = !c.defeated && (c.high ? v > c.setpoint : v < c.setpoint);
      return c.failsafe ? !t : t;
   endfunction
   task automatic results;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ========================================
   // stimulus
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {rst, ce, rxd_pin, factory_reset, alarm_ack, selftest_fail} = 6'h3f;
      {factory_reset, alarm_ack, selftest_fail, go} = 4'h0;
      {cfg_wr, range_sel, supply_fault} = 8'h00;
      {conc, span_ppm, lb} = {16'h3abc, 16'h0100, 1'b0};
      ph = 0;
      cfg_in = analyzer_pkg::CFG_DEF;
      void'($urandom(32'hef1737db));
      tick(6);
      chk({alarm_relay, sys_relay, cal_busy, alarm_defeated_report,
           alarm_tripped_report, report_on}, 16'h0059);
      rst = 1'b0;
      // report bytes cross the fifo while a toggle command arrives
      fork
         begin
            send(analyzer_pkg::CH_S);
            send(analyzer_pkg::CH_T);
            send(analyzer_pkg::CH_CR);
         end
         for (i = 0; i < 3; i++) begin
            for (n = 0; n < 9000 && txd; n++) @(negedge clk);
            chk(txd, 16'h0000);
            #(20 * B);
            for (j = 0; j < 8; j++) #(40 * B) b = {txd, b[7:1]};
            #(40 * B);
            chk({txd, b}, i ? 16'h0140 + 16'(i) : 16'h0133);
         end
      join
      chk(report_on, 16'h0000);
      tick(1);
      for (i = 0; i < 24; i++) begin
         cfg_in = 20'($urandom);
         cfg_in.latching = 1'b0;
         cfg_wr = 2'b01 << i[0];
         tick(1);
         cfg_wr = 2'b00;
         // first two sit exactly on the setpoint
         conc = (i < 2) ? cfg_in.setpoint : 16'($urandom);
         tick(3);
         chk(alarm_relay[i[0]], relay_exp(cfg_in, conc));
      end
      cfg_in = '{1'b0, 1'b1, 1'b0, 1'b1, 16'h0064};
      cfg_wr = 2'b01;
      tick(1);
      {cfg_wr, conc, supply_fault} = {2'b00, 16'h00c8, 4'($urandom) | 4'h1};
      tick(3);
      {conc, supply_fault} = {16'h0032, 4'h0};
      tick(3);
      chk({alarm_relay[0], sys_relay}, 16'h0002);
      ack();
      chk({alarm_relay[0], sys_relay}, 16'h0001);
      selftest_fail = 1'b1;
      tick(3);
      chk(sys_relay, 16'h0000);
      selftest_fail = 1'b0;
      ack();
      chk(sys_relay, 16'h0001);
      {factory_reset, cfg_wr, cfg_in.defeated} = 4'b1110;
      tick(1);
      {factory_reset, cfg_wr} = 3'b000;
      tick(3);
      chk(alarm_defeated_report, 16'h0003);
      for (i = 0; i < 4; i++) begin
         range_sel = 2'(i);
         tick(2);
         chk({air_cal_range_indicator, high_range_indicator,
              medium_range_indicator, low_range_indicator},
             16'(1 << i));
      end
      go = 1'b1;
      for (n = 0; n < 2000 && !pdone; n++) begin
         @(negedge clk);
         if (lb && !cal_busy) ph++;
         lb = cal_busy;
         chk({valve_sample, valve_exhaust, valve_zero, valve_span},
             cal_busy ? (ph == 1 ? 16'h5 : 16'h6) : 16'h8);
      end
      chk(pdone, 16'h0001);
      // zero, span, zero, then the repeat of the held zero
      chk(16'(ph), 16'h0004);
      results();
   end
endmodule
`default_nettype wire
